/* logic/tws_mem.sv */
// Two-clock word memory with byte lane writes and a registered read port.
`timescale 1ns/100ps
`default_nettype none

module tws_mem import tws_pkg::*; (
  // Write port on the core clock.
  input wire logic wr_clk,
  input wire logic wr_en,
  input wire logic [1:0] wr_be,
  input wire logic [MEM_AW-1:0] wr_addr,
  input wire logic [WORD_W-1:0] wr_data,
  // Read port on the shift clock.
  input wire logic rd_clk,
  input wire logic [MEM_AW-1:0] rd_addr,
  output logic [WORD_W-1:0] rd_data_q
);

  logic [WORD_W-1:0] mem [0:(1<<MEM_AW)-1];

  // Lanes are written independently so x8 bytes do not disturb their neighbours.
  always_ff @(posedge wr_clk) begin
    if (wr_en && wr_be[0]) begin
      mem[wr_addr][BYTE_W-1:0] <= wr_data[BYTE_W-1:0];
    end
    if (wr_en && wr_be[1]) begin
      mem[wr_addr][WORD_W-1:BYTE_W] <= wr_data[WORD_W-1:BYTE_W];
    end
  end

  // Read data is registered; a row being programmed may read either value.
  always_ff @(posedge rd_clk) begin
    rd_data_q <= mem[rd_addr];
  end

endmodule

`default_nettype wire

/* logic/tws_pkg.sv */
// Shared constants, types and helpers for the three-wire serial memory block.
`default_nettype none

package tws_pkg;

  // Word, address and memory geometry.
  localparam int ADDR_W = 9;
  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int MEM_AW = 8;
  localparam int CNT_W = 5;
  localparam logic [MEM_AW-1:0] MEM_LAST_INDEX = 8'hFF;

  // Field lengths of an instruction, in shift-clock bits.
  localparam logic [CNT_W-1:0] OPCODE_LEN = 5'h02;
  localparam logic [CNT_W-1:0] ADDR_LEN_X8 = 5'h09;
  localparam logic [CNT_W-1:0] ADDR_LEN_X16 = 5'h08;
  localparam logic [CNT_W-1:0] DATA_LEN_X8 = 5'h08;
  localparam logic [CNT_W-1:0] DATA_LEN_X16 = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;

  // Start bit, operation codes and the qualifiers of operation code 00.
  localparam logic LEADING_ONE_BIT = 1'h1;
  localparam logic DUMMY_BIT = 1'h0;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_ERASE = 2'h3;
  localparam logic [1:0] OP_SPECIAL = 2'h0;
  localparam logic [1:0] QUAL_ENABLE = 2'h3;
  localparam logic [1:0] QUAL_ERASE_ALL = 2'h2;
  localparam logic [1:0] QUAL_WRITE_ALL = 2'h1;
  localparam logic [1:0] QUAL_DISABLE = 2'h0;

  // Data patterns and byte lane enables.
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;
  localparam logic [1:0] LANES_BOTH = 2'h3;
  localparam logic [1:0] LANE_HIGH = 2'h2;
  localparam logic [1:0] LANE_LOW = 2'h1;
  localparam logic [BYTE_W-1:0] BYTE_PAD = 8'h00;

  // Timing: core clock, least select low time and self-timed program time.
  localparam int CORE_CLK_PERIOD_NS = 10;
  localparam int MIN_SELECT_LOW_TIME_NS = 250;
  localparam int MIN_SELECT_LOW_CYCLES_I =
    (MIN_SELECT_LOW_TIME_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam logic [7:0] MIN_SELECT_LOW_CYCLES = 8'(MIN_SELECT_LOW_CYCLES_I);
  localparam int SELF_TIMED_PROGRAM_TIME_US = 3000;
  localparam int PROG_CYCLES_DEFAULT = SELF_TIMED_PROGRAM_TIME_US * 1000 / CORE_CLK_PERIOD_NS;

  // Commands handed from the link domain to the core domain.
  typedef enum logic [2:0] {
    CMD_WRITE, CMD_ERASE, CMD_ERASE_ALL, CMD_WRITE_ALL, CMD_ENABLE, CMD_DISABLE
  } tws_cmd_t;

  // Phases of one select frame on the link.
  typedef enum logic [2:0] {
    LS_IDLE, LS_OPCODE, LS_ADDR, LS_DATA, LS_READ, LS_DONE
  } tws_link_state_t;

  // Maps a device address to a memory row; x8 bytes share a 16-bit row.
  function automatic logic [MEM_AW-1:0] mem_index(input logic [ADDR_W-1:0] addr, input logic wide16);
    mem_index = wide16 ? addr[MEM_AW-1:0] : addr[ADDR_W-1:1];
  endfunction

  // Next sequential address, wrapping within the organisation's range.
  function automatic logic [ADDR_W-1:0] next_addr(input logic [ADDR_W-1:0] addr, input logic wide16);
    logic [ADDR_W-1:0] inc;
    inc = addr + 9'h001;
    next_addr = wide16 ? {1'h0, inc[MEM_AW-1:0]} : inc;
  endfunction

endpackage

`default_nettype wire

/* logic/tws_serial_mem.sv */
// Top of the three-wire serial memory: link decoder, programming engine and status.
// Function
// - Instruction starts on select rise: start one, two-bit opcode, then address field.
// - Opcode 10 reads, 01 writes, 11 erases the addressed location.
// - Opcode 00 uses top address bits: 11 enable, 10 erase all, 01 write all, 00 disable.
// - Read data on the serial output changes only on rising shift clock edges.
// - A read sends one leading zero, then the 8- or 16-bit word.
// - Holding select high streams following words with no extra zero bit.
// - Programming is disabled from power-up until an enable command runs.
// - Enabled programming stays enabled until a disable command or power loss.
// - Erase sets the location to all ones; its timed cycle starts at decode.
// - Write carries 8 or 16 data bits; timed cycle starts after the last bit.
// - Select low long enough, then high, after programming shows status on output.
// - Status reads zero while busy and one once programming has finished.
// - Select raised after the timed cycle ended shows no status.
// - Erase everything sets every bit of the array to one.
// - Write everything programs every location with the following data word.
// - Reads run whether programming is enabled or disabled.
// - Organisation input high or open selects 16-bit words, low selects 8-bit; the code has no pull-up, so an open input is not read as 16-bit.
`timescale 1ns/100ps
`default_nettype none

module tws_serial_mem import tws_pkg::*; #(
  parameter int PROG_CYCLES = PROG_CYCLES_DEFAULT
) (
  // Core clock and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  // Serial link from the host.
  input wire logic serial_shift_clock,
  input wire logic chip_select,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  // Organisation strap.
  input wire logic word_width_select,
  // Observation of internal state.
  output logic programming_busy,
  output logic programming_enabled
);

  localparam logic [31:0] PROG_LAST = 32'(PROG_CYCLES - 1);

  // Reset copies for both domains.
  logic rst_meta_q;
  logic rst_sync_b_q;
  logic lrst_meta_q;
  logic link_rst_b_q;
  logic frame_rst_b;

  // Link domain frame state.
  tws_link_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [WORD_W-1:0] sh_q;
  logic [1:0] op_q;
  logic wide_q;
  logic [ADDR_W-1:0] ptr_q;
  logic [WORD_W-1:0] out_sh_q;
  logic rd_bit_q;
  logic rd_active_q;
  tws_cmd_t data_kind_q;

  // Link domain command hand-off.
  logic req_tgl_q;
  tws_cmd_t cmd_kind_q;
  logic [ADDR_W-1:0] cmd_addr_q;
  logic [WORD_W-1:0] cmd_data_q;
  logic cmd_wide_q;

  // Link domain combinational decode.
  logic [WORD_W-1:0] sh_next;
  logic last_bit;
  logic [CNT_W-1:0] addr_len;
  logic [CNT_W-1:0] data_len;
  logic [ADDR_W-1:0] addr_asm;
  logic [1:0] qual;
  logic fire;
  tws_cmd_t fire_kind;
  logic [MEM_AW-1:0] rd_addr;
  logic [WORD_W-1:0] rd_data;
  logic [WORD_W-1:0] word_aligned;

  // Core domain state.
  logic [1:0] sync_v;
  logic cs_s;
  logic tgl_s;
  logic cs_prev_q;
  logic tgl_prev_q;
  logic req_evt;
  logic cs_rise;
  logic [7:0] low_cnt_q;
  logic status_show_q;
  logic prog_en_q;
  logic busy_q;
  logic [31:0] tmr_q;
  logic start_prog;
  logic walk_q;
  logic walk_all_q;
  logic [MEM_AW-1:0] wr_idx_q;
  logic [WORD_W-1:0] wr_data_q;
  logic [1:0] wr_be_q;

  // Core reset is released through two flops.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_q <= 1'h0;
      rst_sync_b_q <= 1'h0;
    end else begin
      rst_meta_q <= 1'h1;
      rst_sync_b_q <= rst_meta_q;
    end
  end

  // The link domain gets its own release; the host clock may be stopped at that time.
  always_ff @(posedge serial_shift_clock or negedge rst_b) begin
    if (!rst_b) begin
      lrst_meta_q <= 1'h0;
      link_rst_b_q <= 1'h0;
    end else begin
      lrst_meta_q <= 1'h1;
      link_rst_b_q <= lrst_meta_q;
    end
  end

  // A frame ends with select low, since no shift edge is promised after it.
  assign frame_rst_b = chip_select & link_rst_b_q;

  // Field decode from the bits already shifted in plus the current input bit.
  assign sh_next = {sh_q[WORD_W-2:0], serial_data_in};
  assign last_bit = (cnt_q == CNT_ONE);
  assign addr_len = wide_q ? ADDR_LEN_X16 : ADDR_LEN_X8;
  assign data_len = wide_q ? DATA_LEN_X16 : DATA_LEN_X8;
  assign addr_asm = wide_q ? {1'h0, sh_next[MEM_AW-1:0]} : sh_next[ADDR_W-1:0];
  assign qual = wide_q ? sh_next[MEM_AW-1:MEM_AW-2] : sh_next[ADDR_W-1:ADDR_W-2];

  // Which command, if any, completes on this shift edge.
  always_comb begin
    fire = 1'h0;
    fire_kind = CMD_WRITE;
    if (state_q == LS_ADDR && last_bit) begin
      if (op_q == OP_ERASE) begin
        fire = 1'h1;
        fire_kind = CMD_ERASE;
      end else if (op_q == OP_SPECIAL && qual != QUAL_WRITE_ALL) begin
        fire = 1'h1;
        unique case (qual)
          QUAL_ENABLE: fire_kind = CMD_ENABLE;
          QUAL_ERASE_ALL: fire_kind = CMD_ERASE_ALL;
          QUAL_DISABLE: fire_kind = CMD_DISABLE;
          default: fire_kind = CMD_DISABLE;
        endcase
      end
    end else if (state_q == LS_DATA && last_bit) begin
      fire = 1'h1;
      fire_kind = data_kind_q;
    end
  end

  // Frame sequencer: start bit, opcode, full address field, then data or read stream.
  always_ff @(posedge serial_shift_clock or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      state_q <= LS_IDLE;
      cnt_q <= CNT_ZERO;
      op_q <= OP_SPECIAL;
      wide_q <= 1'h1;
      ptr_q <= '0;
      data_kind_q <= CMD_WRITE;
    end else begin
      unique case (state_q)
        LS_IDLE: begin
          if (serial_data_in == LEADING_ONE_BIT) begin
            state_q <= LS_OPCODE;
            cnt_q <= OPCODE_LEN;
            wide_q <= word_width_select;
          end
        end
        LS_OPCODE: begin
          if (last_bit) begin
            op_q <= sh_next[1:0];
            state_q <= LS_ADDR;
            cnt_q <= addr_len;
          end else begin
            cnt_q <= cnt_q - CNT_ONE;
          end
        end
        LS_ADDR: begin
          if (!last_bit) begin
            cnt_q <= cnt_q - CNT_ONE;
          end else if (op_q == OP_READ) begin
            state_q <= LS_READ;
            ptr_q <= addr_asm;
            cnt_q <= CNT_ZERO;
          end else if (op_q == OP_WRITE || (op_q == OP_SPECIAL && qual == QUAL_WRITE_ALL)) begin
            state_q <= LS_DATA;
            ptr_q <= addr_asm;
            cnt_q <= data_len;
            data_kind_q <= (op_q == OP_WRITE) ? CMD_WRITE : CMD_WRITE_ALL;
          end else begin
            state_q <= LS_DONE;
          end
        end
        LS_DATA: begin
          if (last_bit) begin
            state_q <= LS_DONE;
          end else begin
            cnt_q <= cnt_q - CNT_ONE;
          end
        end
        LS_READ: begin
          if (cnt_q == CNT_ZERO) begin
            cnt_q <= data_len - CNT_ONE;
            ptr_q <= next_addr(ptr_q, wide_q);
          end else begin
            cnt_q <= cnt_q - CNT_ONE;
          end
        end
        LS_DONE: begin
          state_q <= LS_DONE;
        end
      endcase
    end
  end

  // Bits shift in on every rising edge of a frame; the field length picks them out.
  always_ff @(posedge serial_shift_clock or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      sh_q <= '0;
    end else begin
      sh_q <= sh_next;
    end
  end

  // The memory reads the decoded address on the last address edge, then the pointer.
  assign rd_addr = (state_q == LS_ADDR && last_bit) ? mem_index(addr_asm, wide_q) : mem_index(ptr_q, wide_q);
  assign word_aligned = wide_q ? rd_data
                      : {(ptr_q[0] ? rd_data[WORD_W-1:BYTE_W] : rd_data[BYTE_W-1:0]), BYTE_PAD};

  // Read output: one zero after the address, then words back to back, all on rising edges.
  always_ff @(posedge serial_shift_clock or negedge frame_rst_b) begin
    if (!frame_rst_b) begin
      rd_active_q <= 1'h0;
      rd_bit_q <= 1'h0;
      out_sh_q <= '0;
    end else if (state_q == LS_ADDR && last_bit && op_q == OP_READ) begin
      rd_active_q <= 1'h1;
      rd_bit_q <= DUMMY_BIT;
    end else if (state_q == LS_READ && cnt_q == CNT_ZERO) begin
      rd_bit_q <= word_aligned[WORD_W-1];
      out_sh_q <= {word_aligned[WORD_W-2:0], 1'h0};
    end else if (state_q == LS_READ) begin
      rd_bit_q <= out_sh_q[WORD_W-1];
      out_sh_q <= {out_sh_q[WORD_W-2:0], 1'h0};
    end
  end

  // Command fields stay stable for many core cycles before the toggle is seen there.
  always_ff @(posedge serial_shift_clock or negedge link_rst_b_q) begin
    if (!link_rst_b_q) begin
      req_tgl_q <= 1'h0;
      cmd_kind_q <= CMD_DISABLE;
      cmd_addr_q <= '0;
      cmd_data_q <= '0;
      cmd_wide_q <= 1'h1;
    end else if (fire) begin
      req_tgl_q <= ~req_tgl_q;
      cmd_kind_q <= fire_kind;
      cmd_addr_q <= (state_q == LS_ADDR) ? addr_asm : ptr_q;
      cmd_data_q <= wide_q ? sh_next : {BYTE_PAD, sh_next[BYTE_W-1:0]};
      cmd_wide_q <= wide_q;
    end
  end

  // Select and the command toggle cross into the core domain together.
  tws_sync3 #(.WIDTH(2)) u_sync (
    .clk(core_clk),
    .rst_b(rst_sync_b_q),
    .async_in({req_tgl_q, chip_select}),
    .sync_out(sync_v)
  );

  assign cs_s = sync_v[0];
  assign tgl_s = sync_v[1];
  assign req_evt = tgl_s ^ tgl_prev_q;
  assign cs_rise = cs_s & ~cs_prev_q;

  // Edge history of the crossed signals.
  always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      cs_prev_q <= 1'h0;
      tgl_prev_q <= 1'h0;
    end else begin
      cs_prev_q <= cs_s;
      tgl_prev_q <= tgl_s;
    end
  end

  // Select low time is measured so a too-short low pulse does not open status.
  always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      low_cnt_q <= '0;
    end else if (cs_s) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q != MIN_SELECT_LOW_CYCLES) begin
      low_cnt_q <= low_cnt_q + 8'h01;
    end
  end

  // Status opens only when select rises during a cycle after a long enough low.
  always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      status_show_q <= 1'h0;
    end else if (!cs_s) begin
      status_show_q <= 1'h0;
    end else if (cs_rise) begin
      status_show_q <= busy_q && (low_cnt_q == MIN_SELECT_LOW_CYCLES);
    end
  end

  // Programming permission: off at reset, changed only by its two commands.
  always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      prog_en_q <= 1'h0;
    end else if (req_evt && cmd_kind_q == CMD_ENABLE) begin
      prog_en_q <= 1'h1;
    end else if (req_evt && cmd_kind_q == CMD_DISABLE) begin
      prog_en_q <= 1'h0;
    end
  end

  // A program command is refused while disabled or while a cycle is still running.
  assign start_prog = req_evt && prog_en_q && !busy_q && cmd_kind_q != CMD_ENABLE && cmd_kind_q != CMD_DISABLE;

  // Self-timed cycle: busy for the program time and until the array walk is done.
  always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      busy_q <= 1'h0;
      tmr_q <= '0;
    end else if (start_prog) begin
      busy_q <= 1'h1;
      tmr_q <= '0;
    end else if (busy_q && tmr_q >= PROG_LAST && !walk_q) begin
      busy_q <= 1'h0;
    end else if (busy_q && tmr_q < PROG_LAST) begin
      tmr_q <= tmr_q + 32'h00000001;
    end
  end

  // Array writes: one row for single commands, every row for the whole-array ones.
  always_ff @(posedge core_clk or negedge rst_sync_b_q) begin
    if (!rst_sync_b_q) begin
      walk_q <= 1'h0;
      walk_all_q <= 1'h0;
      wr_idx_q <= '0;
      wr_data_q <= '0;
      wr_be_q <= '0;
    end else if (start_prog) begin
      walk_q <= 1'h1;
      walk_all_q <= (cmd_kind_q == CMD_ERASE_ALL) || (cmd_kind_q == CMD_WRITE_ALL);
      wr_idx_q <= (cmd_kind_q == CMD_ERASE_ALL || cmd_kind_q == CMD_WRITE_ALL) ? '0
                : mem_index(cmd_addr_q, cmd_wide_q);
      if (cmd_kind_q == CMD_ERASE || cmd_kind_q == CMD_ERASE_ALL) begin
        wr_data_q <= ERASED_WORD;
      end else if (cmd_wide_q) begin
        wr_data_q <= cmd_data_q;
      end else begin
        wr_data_q <= {cmd_data_q[BYTE_W-1:0], cmd_data_q[BYTE_W-1:0]};
      end
      if (cmd_wide_q || cmd_kind_q == CMD_ERASE_ALL || cmd_kind_q == CMD_WRITE_ALL) begin
        wr_be_q <= LANES_BOTH;
      end else begin
        wr_be_q <= cmd_addr_q[0] ? LANE_HIGH : LANE_LOW;
      end
    end else if (walk_q) begin
      if (!walk_all_q || wr_idx_q == MEM_LAST_INDEX) begin
        walk_q <= 1'h0;
      end else begin
        wr_idx_q <= wr_idx_q + 8'h01;
      end
    end
  end

  // Storage array shared by the write engine and the read stream.
  tws_mem u_mem (
    .wr_clk(core_clk),
    .wr_en(walk_q),
    .wr_be(wr_be_q),
    .wr_addr(wr_idx_q),
    .wr_data(wr_data_q),
    .rd_clk(serial_shift_clock),
    .rd_addr(rd_addr),
    .rd_data_q(rd_data)
  );

  // Output pin: read bits while streaming, otherwise ready status; released when select is low.
  assign serial_data_out = rd_active_q ? rd_bit_q : ~busy_q;
  assign serial_data_out_oe = chip_select & (rd_active_q | status_show_q);
  assign programming_busy = busy_q;
  assign programming_enabled = prog_en_q;

endmodule

`default_nettype wire

/* logic/tws_sync3.sv */
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none

module tws_sync3 import tws_pkg::*; #(
  parameter int WIDTH = 2
) (
  // Destination clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous input and settled output.
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;

  // The first stage feeds only the second, so metastability never reaches a gate.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Each bit moves only when the two settled stages agree, filtering one-stage glitches.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign sync_out = out_q;

endmodule

`default_nettype wire

/* verification/tws_host.sv */
// Host model: drives select, shift clock and data in.
`timescale 1ns/100ps
`default_nettype none
module tws_host (
  // Link outputs.
  output logic sclk,
  output logic cs,
  output logic di,
  // Device answer.
  input wire logic so,
  input wire logic soe
);
  initial begin
    sclk = 1'b0;
    cs = 1'b0;
    di = 1'b0;
  end
  // Sends n bits MSB first and keeps one sample per shift clock.
  task automatic frame(input logic [63:0] v, input int n, output logic [63:0] got);
    got = '0;
    // Two edges with select low let the link reset copy settle.
    repeat (2) begin
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
    end
    cs = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      di = v[i];
      #7.5 sclk = 1'b1;
      #7.5 sclk = 1'b0;
      // A released output shows the inverse of its last level, so an undriven bit cannot pass as data.
      got = {got[62:0], soe ? so : ~so};
    end
    cs = 1'b0;
    di = ~di;
  endtask
  task automatic select(input logic v);
    cs = v;
  endtask
endmodule
`default_nettype wire

/* verification/tws_serial_mem_assertions.sv */
// Port checks of the serial memory top.
`timescale 1ns/100ps
`default_nettype none
module tws_checker #(
  parameter int PROG_CYCLES = 400
) (
  // Clocks and reset.
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic serial_shift_clock,
  // Link pins.
  input wire logic chip_select,
  input wire logic serial_data_out,
  input wire logic serial_data_out_oe,
  // State.
  input wire logic programming_busy,
  input wire logic programming_enabled
);
  logic [15:0] low_cnt_q;
  logic [31:0] busy_cnt_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // Select low time; saturates so a long idle cannot wrap back into range.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b || chip_select) begin
      low_cnt_q <= 16'h0000;
    end else if (low_cnt_q != 16'hFFFF) begin
      low_cnt_q <= low_cnt_q + 16'h0001;
    end
  end
  // Length of the current busy spell.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b || !programming_busy) begin
      busy_cnt_q <= 32'h00000000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 32'h00000001;
    end
  end
  sequence s_status_ask;
    $rose(chip_select) && programming_busy && low_cnt_q >= 16'h0019;
  endsequence
  sel_low_release_a: assert property (!chip_select |-> !serial_data_out_oe)
    else $error("output driven with select low");
  status_shown_a: assert property (s_status_ask |-> ##[2:8] serial_data_out_oe)
    else $error("no status after select rise");
  dummy_busy_zero_a: assert property ($rose(serial_data_out_oe) && programming_busy |-> !serial_data_out)
    else $error("busy status not zero");
  ready_one_a: assert property (serial_data_out_oe && chip_select && $fell(programming_busy) |-> serial_data_out)
    else $error("ready status not one");
  no_late_status_a: assert property ($rose(chip_select) && !programming_busy |-> !serial_data_out_oe [*8])
    else $error("status shown when idle");
  prog_gated_a: assert property ($rose(programming_busy) |-> programming_enabled)
    else $error("programming while disabled");
  enable_sticky_a: assert property ($changed(programming_enabled) |-> low_cnt_q < 16'h0010)
    else $error("enable changed without a command");
  busy_length_a: assert property ($fell(programming_busy) |->
    busy_cnt_q >= PROG_CYCLES - 2 && busy_cnt_q <= PROG_CYCLES + 2)
    else $error("timed cycle length wrong");
endmodule
`default_nettype wire

/* verification/tws_serial_mem_test.sv */
// Self-checking bench of the serial memory top.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tws_serial_mem_test import tws_pkg::*; ;
  logic core_clk, rst_b, word_width_select, sclk, cs, di, so, soe, busy, enabled;
  logic [63:0] got;
  int failures, total_checks;
  tws_serial_mem #(.PROG_CYCLES(400)) DUT (.core_clk(core_clk), .rst_b(rst_b), .serial_shift_clock(sclk),
    .chip_select(cs), .serial_data_in(di), .serial_data_out(so), .serial_data_out_oe(soe),
    .word_width_select(word_width_select), .programming_busy(busy), .programming_enabled(enabled));
  tws_host host (.sclk(sclk), .cs(cs), .di(di), .so(so), .soe(soe));
  always #5 core_clk = ~core_clk;
  // Select stays low 300 ns after every frame, beyond the least low time.
  task automatic run(input logic [63:0] v, input int n);
    host.frame(v, n, got);
    #300;
    // Later select changes then fall on a core falling edge, away from its sampling edge.
    @(negedge core_clk);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge core_clk);
    `CHK(busy, 1'b0)
  endtask
  task automatic status(input logic oe_exp);
    host.select(1'b1);
    repeat (8) @(negedge core_clk);
    `CHK(soe, oe_exp)
  endtask
  task automatic t_write_status;
    `CHK(enabled, 1'b0)
    run({LEADING_ONE_BIT, OP_WRITE, 8'h05, 16'h1234}, 27);
    `CHK(busy, 1'b0)
    run({LEADING_ONE_BIT, OP_SPECIAL, QUAL_ENABLE, 6'h00}, 11);
    `CHK(enabled, 1'b1)
    run({LEADING_ONE_BIT, OP_WRITE, 8'h05, 16'hA5C3}, 27);
    `CHK(busy, 1'b1)
    status(1'b1);
    `CHK(so, 1'b0)
    wait_idle();
    `CHK(so, 1'b1)
    host.select(1'b0);
    #300;
    run({LEADING_ONE_BIT, OP_WRITE, 8'h06, 16'h0F0F}, 27);
    wait_idle();
    status(1'b0);
    host.select(1'b0);
    #300;
    run({LEADING_ONE_BIT, OP_READ, 8'h05, 32'h0}, 43);
    `CHK(got[32:0], {1'b0, 16'hA5C3, 16'h0F0F})
    $display("test write_status done");
  endtask
  task automatic t_all;
    run({LEADING_ONE_BIT, OP_SPECIAL, QUAL_WRITE_ALL, 6'h00, 16'h3C3C}, 27);
    wait_idle();
    run({LEADING_ONE_BIT, OP_ERASE, 8'hC7}, 11);
    `CHK(busy, 1'b1)
    wait_idle();
    run({LEADING_ONE_BIT, OP_READ, 8'hC6, 32'h0}, 43);
    `CHK(got[32:0], {1'b0, 16'h3C3C, 16'hFFFF})
    run({LEADING_ONE_BIT, OP_SPECIAL, QUAL_ERASE_ALL, 6'h00}, 11);
    wait_idle();
    run({LEADING_ONE_BIT, OP_READ, 8'hFF, 32'h0}, 43);
    `CHK(got[32:0], {1'b0, 16'hFFFF, 16'hFFFF})
    $display("test all_words done");
  endtask
  task automatic t_x8_disable;
    @(negedge core_clk) word_width_select = 1'b0;
    run({LEADING_ONE_BIT, OP_WRITE, 9'h009, 8'h5A}, 20);
    wait_idle();
    run({LEADING_ONE_BIT, OP_READ, 9'h008, 16'h0}, 28);
    `CHK(got[16:0], {1'b0, 8'hFF, 8'h5A})
    @(negedge core_clk) word_width_select = 1'b1;
    run({LEADING_ONE_BIT, OP_WRITE, 3'h0}, 6);
    `CHK(busy, 1'b0)
    run({LEADING_ONE_BIT, OP_SPECIAL, QUAL_DISABLE, 6'h00}, 11);
    `CHK(enabled, 1'b0)
    run({LEADING_ONE_BIT, OP_ERASE, 8'h04}, 11);
    `CHK(busy, 1'b0)
    run({LEADING_ONE_BIT, OP_READ, 8'h04, 16'h0}, 27);
    `CHK(got[16:0], {1'b0, 16'h5AFF})
    $display("test x8_disable done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    rst_b = 1'b0;
    word_width_select = 1'b1;
    failures = 0;
    total_checks = 0;
    repeat (4) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge core_clk);
    t_write_status();
    t_all();
    t_x8_disable();
    conclude();
  end
  // The tests need about 35 us; a hang is cut off well beyond that.
  initial begin
    #400000;
    failures++;
    conclude();
  end
endmodule
bind tws_serial_mem tws_checker #(.PROG_CYCLES(PROG_CYCLES)) chk (.core_clk(core_clk), .rst_b(rst_b),
  .serial_shift_clock(serial_shift_clock), .chip_select(chip_select), .serial_data_out(serial_data_out),
  .serial_data_out_oe(serial_data_out_oe), .programming_busy(programming_busy),
  .programming_enabled(programming_enabled));
`default_nettype wire
